// file: rtl/bdf_pkg.sv
// constants for the two-way dual-port fifo core: pin vector layout, presets, counts
// assumes every pin is sampled on ref_clk through a three-stage synchroniser
// Functional notes
// - reset low four edges of both port clocks
// - reset clears pointers, flags low, almost-full/mail high
// - space flag rises two writer edges after release
// - offset selects captured at reset rising edge
// - mode pin sampled at first writer edge
// - standard mode: every word needs a read
// - fall-through mode: first word appears unrequested
// - first four fifo1 writes load offsets
// - offsets from low port a data bits
// - port b space rises after offsets loaded
// - port a drives only with select, direction low
// - port a write qualified into fifo1
// - port a read qualified from fifo2
// - port b drives with select low, direction high
// - port b write fifo2, read fifo1
// - fall-through loads output on availability edge
// - flags pass two stages in reader domain
// - reads ignored while availability flag low
// - fall-through word visible third reader edge
// - standard availability rises second reader edge
// - writes ignored while space flag low
package bdf_pkg;
    // pin vector bit positions
    localparam int PIN_W    = 87;
    localparam int CLK_POS  = 0;   // port a clock, port b clock at +1
    localparam int RST_POS  = 2;   // fifo1 reset, fifo2 reset at +1
    localparam int FS0_POS  = 4;
    localparam int FS1_POS  = 5;
    localparam int MODE_POS = 6;
    localparam int CTL_POS  = 7;   // four control bits per port
    localparam int CTL_STEP = 4;
    localparam int CS_OFF   = 0;
    localparam int DIR_OFF  = 1;
    localparam int GATE_OFF = 2;
    localparam int MB_OFF   = 3;
    localparam int DATA_POS = 15;  // port a data, port b data follows
    localparam int DATA_W   = 36;
    // timing counts in writer port edges
    localparam logic [1:0] RESET_WAIT = 2'h2;
    localparam logic [2:0] PROG_WORDS = 3'h4;
    // preset offsets chosen by the offset selects
    localparam logic [1:0] FS_PROG  = 2'h0;
    localparam logic [1:0] FS_P8    = 2'h1;
    localparam logic [1:0] FS_P16   = 2'h2;
    localparam logic [6:0] PRESET_8  = 7'h08;
    localparam logic [6:0] PRESET_16 = 7'h10;
    localparam logic [6:0] PRESET_64 = 7'h40;
endpackage

// file: rtl/bdf_core.sv
// two opposite fifos between port a and port b, all on ref_clk
// assumes port clocks and controls are slow pins sampled here; tri-state resolved outside
`timescale 1ns/1ps
module bdf_core #(
    parameter int AW = 10                          // depth is 2**AW words
) (
    // system
    input  wire logic                ref_clk,
    input  wire logic                reset,
    // port clocks, fifo resets, shared offset and mode selects
    input  wire logic                portAClock,
    input  wire logic                portBClock,
    input  wire logic                fifo1MasterResetN,
    input  wire logic                fifo2MasterResetN,
    input  wire logic                offsetSelect0,
    input  wire logic                offsetSelect1,
    input  wire logic                timingModeSelect,
    // port a
    input  wire logic                portASelectN,
    input  wire logic                portADirection,
    input  wire logic                portAXferGate,
    input  wire logic                portAMailSelect,
    input  wire logic [35:0]         portADataIn,
    output logic      [35:0]         portADataOut,
    output logic                     portADataOe,
    output logic                     portASpaceFlag,
    output logic                     portADataAvailFlag,
    output logic                     almostEmptyPortA,
    output logic                     almostFullPortA,
    // port b
    input  wire logic                portBSelectN,
    input  wire logic                portBDirection,
    input  wire logic                portBXferGate,
    input  wire logic                portBMailSelect,
    input  wire logic [35:0]         portBDataIn,
    output logic      [35:0]         portBDataOut,
    output logic                     portBDataOe,
    output logic                     portBSpaceFlag,
    output logic                     portBDataAvailFlag,
    output logic                     almostEmptyPortB,
    output logic                     almostFullPortB,
    // mailbox flags, mailboxes themselves live elsewhere
    output logic                     mail1FullFlagN,
    output logic                     mail2FullFlagN
);
    localparam int DEPTH = 1 << AW;
    localparam int PW    = bdf_pkg::PIN_W;

    // whole state; index 0 is fifo1 (a->b), index 1 is fifo2 (b->a)
    typedef struct packed {
        logic [PW-1:0]                s1, s2, s3, stab;  // synchroniser and stable pins
        logic [1:0][DEPTH-1:0][35:0]  mem;               // storage, flip-flops
        logic [1:0][AW:0]             wp, rp;            // pointers, extra wrap bit
        logic [1:0][AW:0]             wpS1, wpS2;        // write pointer seen by reader
        logic [1:0][AW:0]             rpS1, rpS2;        // read pointer seen by writer
        logic [1:0][1:0]              rstWait;           // writer edges since release
        logic [1:0]                   modeStd, modeSet;  // 1 = standard timing
        logic [1:0]                   space, avail;      // full/ready and empty/ready
        logic [1:0]                   almEmpty, almFull;
        logic                         progMode;          // offsets still to load
        logic [2:0]                   progIdx;
        logic [1:0][35:0]             outReg;            // fifo output registers
        logic [1:0][AW-1:0]           xOff, yOff;        // almost empty / full offsets
        logic [1:0]                   oe;
        logic [1:0]                   mailN;
    } bdf_state_t;

    bdf_state_t q;  // registered state
    bdf_state_t n;  // next state

    // qualified transfer on a port; wr selects write, port b direction is inverted
    function automatic logic xferReq(input logic [PW-1:0] s, input int p, input logic wr);
        int  b;
        logic dirW;
        b    = bdf_pkg::CTL_POS + bdf_pkg::CTL_STEP * p;
        dirW = (p == 0) ? s[b + bdf_pkg::DIR_OFF] : !s[b + bdf_pkg::DIR_OFF];
        return !s[b + bdf_pkg::CS_OFF] && (dirW == wr) && s[b + bdf_pkg::GATE_OFF] && !s[b + bdf_pkg::MB_OFF];
    endfunction

    // preset offset for a non-programming select code
    function automatic logic [AW-1:0] presetOff(input logic [1:0] fs);
        logic [6:0] v;
        v = (fs == bdf_pkg::FS_P8) ? bdf_pkg::PRESET_8 :
            (fs == bdf_pkg::FS_P16) ? bdf_pkg::PRESET_16 : bdf_pkg::PRESET_64;
        return AW'(v);
    endfunction

    // next-state logic for both fifos
    always_comb
    begin
        logic [1:0] edg;
        logic [AW:0] cnt;
        logic [1:0] fs;
        int w, r, dIn;
        edg = '0;
        cnt = '0;
        fs  = '0;
        w   = 0;
        r   = 0;
        dIn = 0;
        n   = q;
        // first stage feeds only the second
        n.s1 = {portBDataIn, portADataIn, portBMailSelect, portBXferGate, portBDirection, portBSelectN,
                portAMailSelect, portAXferGate, portADirection, portASelectN, timingModeSelect,
                offsetSelect1, offsetSelect0, fifo2MasterResetN, fifo1MasterResetN, portBClock, portAClock};
        n.s2 = q.s1;
        n.s3 = q.s2;
        // a pin change counts once second and third stage agree
        for (int i = 0; i < PW; i++)
        begin
            n.stab[i] = (q.s2[i] == q.s3[i]) ? q.s2[i] : q.stab[i];
        end
        for (int p = 0; p < 2; p++)
        begin
            edg[p] = n.stab[bdf_pkg::CLK_POS + p] & ~q.stab[bdf_pkg::CLK_POS + p];
        end
        for (int f = 0; f < 2; f++)
        begin
            w   = f;        // writer port
            r   = 1 - f;    // reader port
            dIn = bdf_pkg::DATA_POS + bdf_pkg::DATA_W * w;
            if (!n.stab[bdf_pkg::RST_POS + f])
            begin
                n.wp[f]       = '0;
                n.rp[f]       = '0;
                n.wpS1[f]     = '0;
                n.wpS2[f]     = '0;
                n.rpS1[f]     = '0;
                n.rpS2[f]     = '0;
                n.space[f]    = 1'b0;
                n.avail[f]    = 1'b0;
                n.almEmpty[f] = 1'b0;
                n.almFull[f]  = 1'b1;
                n.mailN[f]    = 1'b1;
                n.rstWait[f]  = '0;
                n.modeSet[f]  = 1'b0;
            end
            else
            begin
                if (!q.stab[bdf_pkg::RST_POS + f])
                begin
                    fs = {q.stab[bdf_pkg::FS1_POS], q.stab[bdf_pkg::FS0_POS]};
                    if (fs == bdf_pkg::FS_PROG)
                    begin
                        if (f == 0)
                        begin
                            n.progMode = 1'b1;
                            n.progIdx  = '0;
                        end
                    end
                    else
                    begin
                        n.xOff[f] = presetOff(fs);
                        n.yOff[f] = presetOff(fs);
                    end
                end
                // writer side
                if (edg[w])
                begin
                    // mode taken once, first writer edge
                    if (!q.modeSet[f])
                    begin
                        n.modeStd[f] = q.stab[bdf_pkg::MODE_POS];
                        n.modeSet[f] = 1'b1;
                    end
                    // read pointer through two writer stages
                    n.rpS1[f] = q.rp[f];
                    n.rpS2[f] = q.rpS1[f];
                    if (q.rstWait[f] != bdf_pkg::RESET_WAIT)
                    begin
                        n.rstWait[f] = q.rstWait[f] + 2'h1;
                    end
                    if (q.space[f] && xferReq(q.stab, w, 1'b1))
                    begin
                        if (f == 0 && q.progMode)
                        begin
                            unique case (q.progIdx[1:0])
                                2'h0:    n.yOff[0] = q.stab[dIn +: AW];
                                2'h1:    n.xOff[0] = q.stab[dIn +: AW];
                                2'h2:    n.yOff[1] = q.stab[dIn +: AW];
                                default: n.xOff[1] = q.stab[dIn +: AW];
                            endcase
                            n.progIdx = q.progIdx + 3'h1;
                            n.progMode = (n.progIdx != bdf_pkg::PROG_WORDS);
                        end
                        else
                        begin
                            n.mem[f][q.wp[f][AW-1:0]] = q.stab[dIn +: bdf_pkg::DATA_W];
                            n.wp[f] = q.wp[f] + (AW+1)'(1);
                        end
                    end
                    cnt = n.wp[f] - n.rpS2[f];
                    // port b space waits for offset loading
                    n.space[f]   = (n.rstWait[f] == bdf_pkg::RESET_WAIT) && (cnt != (AW+1)'(DEPTH))
                                   && !(f == 1 && n.progMode);
                    n.almFull[f] = cnt < ((AW+1)'(DEPTH) - {1'b0, n.yOff[f]});
                end
                // reader side
                if (edg[r])
                begin
                    // write pointer through two reader stages
                    n.wpS1[f] = q.wp[f];
                    n.wpS2[f] = q.wpS1[f];
                    if (q.modeStd[f])
                    begin
                        if (q.avail[f] && xferReq(q.stab, r, 1'b0))
                        begin
                            n.outReg[f] = q.mem[f][q.rp[f][AW-1:0]];
                            n.rp[f]     = q.rp[f] + (AW+1)'(1);
                        end
                        // flag rises on second reader edge
                        n.avail[f] = n.wpS2[f] != n.rp[f];
                    end
                    else if (!q.avail[f] || xferReq(q.stab, r, 1'b0))
                    begin
                        // third edge loads and raises ready
                        // compare the second stage as it stood before this edge: the load lands one
                        // reader edge after the standard flag would rise, the third sync cycle
                        if (q.wpS2[f] != q.rp[f])
                        begin
                            n.outReg[f] = q.mem[f][q.rp[f][AW-1:0]];
                            n.rp[f]     = q.rp[f] + (AW+1)'(1);
                            n.avail[f]  = 1'b1;
                        end
                        else
                        begin
                            n.avail[f] = 1'b0;
                        end
                    end
                    cnt = n.wpS2[f] - n.rp[f];
                    n.almEmpty[f] = cnt > {1'b0, n.xOff[f]};
                end
            end
        end
        n.oe[0] = !n.stab[bdf_pkg::CTL_POS + bdf_pkg::CS_OFF] && !n.stab[bdf_pkg::CTL_POS + bdf_pkg::DIR_OFF];
        n.oe[1] = !n.stab[bdf_pkg::CTL_POS + bdf_pkg::CTL_STEP + bdf_pkg::CS_OFF]
                  && n.stab[bdf_pkg::CTL_POS + bdf_pkg::CTL_STEP + bdf_pkg::DIR_OFF];
    end

    // state register; async reset loads constants only
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            q         <= '0;
            q.almFull <= 2'h3;
            q.mailN   <= 2'h3;
        end
        else
        begin
            q <= n;
        end
    end

    // outputs straight from state flops
    assign portADataOut       = q.outReg[1];
    assign portBDataOut       = q.outReg[0];
    assign portADataOe        = q.oe[0];
    assign portBDataOe        = q.oe[1];
    assign portASpaceFlag     = q.space[0];
    assign portBSpaceFlag     = q.space[1];
    assign portADataAvailFlag = q.avail[1];
    assign portBDataAvailFlag = q.avail[0];
    assign almostEmptyPortA   = q.almEmpty[1];
    assign almostEmptyPortB   = q.almEmpty[0];
    assign almostFullPortA    = q.almFull[0];
    assign almostFullPortB    = q.almFull[1];
    assign mail1FullFlagN     = q.mailN[0];
    assign mail2FullFlagN     = q.mailN[1];

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    AST_RESET_FLAGS: assert property (!q.s2[bdf_pkg::RST_POS] && !q.s3[bdf_pkg::RST_POS]
        |=> !portASpaceFlag && !portBDataAvailFlag && almostFullPortA && !almostEmptyPortB)
        else $error("fifo1 reset did not clear flags");
    AST_SPACE_WAIT: assert property ($rose(portASpaceFlag) |-> q.rstWait[0] == 2'h2)
        else $error("space flag rose before two writer edges");
    AST_PROG_HOLD: assert property ($rose(portBSpaceFlag) |-> !q.progMode)
        else $error("port b space rose during offset loading");
    AST_OE_A: assert property (portADataOe |-> !q.stab[bdf_pkg::CTL_POS] && !q.stab[bdf_pkg::CTL_POS + 1])
        else $error("port a driven while deselected");
    AST_OE_B: assert property (portBDataOe |-> !q.stab[bdf_pkg::CTL_POS + 4] && q.stab[bdf_pkg::CTL_POS + 5])
        else $error("port b driven while deselected");
    AST_NO_FULL_WRITE: assert property ($changed(q.wp[0]) && q.stab[bdf_pkg::RST_POS] |-> $past(q.space[0]))
        else $error("write taken while full");
    // a fifo reset rewinds the pointers as well, so only released cycles count
    AST_HOLD_EMPTY: assert property ($changed(q.rp[0]) && q.modeStd[0] && q.stab[bdf_pkg::RST_POS]
        |-> $past(portBDataAvailFlag))
        else $error("standard read taken while empty");
    AST_FALL_THROUGH_MODE_LOAD: assert property ($rose(portBDataAvailFlag) && !q.modeStd[0] |-> $changed(q.rp[0]))
        else $error("ready rose without loading a word");
    AST_SYNC_STAGE: assert property ($changed(q.wpS2[0]) && q.stab[bdf_pkg::RST_POS]
        |-> q.wpS2[0] == $past(q.wpS1[0]))
        else $error("pointer skipped a sync stage");

    COV_FALL_THROUGH_MODE_B: cover property ($rose(portBDataAvailFlag) && !q.modeStd[0]);
    COV_PROG_DONE: cover property (q.progMode ##1 !q.progMode);
    COV_READ_A: cover property ($rose(portADataAvailFlag));
endmodule

// file: verif/bdf_port_host.sv
// port-side bus master model: one synchronous port host with its own port clock
// assumes the core samples pins on ref_clk; the host changes pins on falling ref_clk
`timescale 1ns/1ps
module bdf_port_host #(
    parameter logic READ_DIR = 1'b0,  // direction level that means a read
    parameter int   HALF     = 6      // ref_clk cycles per high port clock phase, low phase one more
) (
    // system
    input  wire logic        ref_clk,
    // port pins
    output logic             portClk,
    output logic             selN,
    output logic             dir,
    output logic             gate,
    output logic [35:0]      drive
);
    logic wasRead;  // last cycle was a qualified read attempt
    event done;     // a port cycle has finished, outputs settled

    // idle pins at time zero, clock parked low
    initial
    begin
        portClk = 1'b0;
        selN = 1'b1;
        dir = 1'b0;
        gate = 1'b0;
        drive = 36'h0;
        wasRead = 1'b0;
    end

    // one port clock period; controls held well past the rising edge
    task automatic cycle(input logic s, input logic d, input logic g, input logic [35:0] w);
        @(negedge ref_clk);
        selN = s;
        dir = d;
        gate = g;
        drive = w;
        wasRead = !s && g && (d == READ_DIR);
        repeat (HALF) @(negedge ref_clk);
        portClk = 1'b1;
        repeat (HALF) @(negedge ref_clk);
        portClk = 1'b0;
        gate = 1'b0;
        // released bus shows the inverse, so a stale word can never pass
        drive = ~drive;
        -> done;
    endtask

    // static select and direction without a clock, for output enable checks
    task automatic pins(input logic s, input logic d);
        @(negedge ref_clk);
        selN = s;
        dir = d;
    endtask
endmodule

// file: verif/bidir_dual_clock_fifo_core_tb_top.sv
// self-checking bench: reset, offset load, both directions, full, enables, fall-through
// assumes two port host models with a thirteen ref_clk port clock period
`timescale 1ns/1ps
module bidir_dual_clock_fifo_core_tb_top;
    localparam int AW    = 3;  // short depth keeps the full case quick
    localparam int DEPTH = 8;
    // clock, resets, shared pins
    logic        ref_clk, reset, rst1N, rst2N, modeSel;
    logic [1:0]  fsel;
    // port pins and flags
    logic        aClk, aSelN, aDir, aGate, aOe, aSpace, aAvail, aAe, aAf;
    logic        bClk, bSelN, bDir, bGate, bOe, bSpace, bAvail, bAe, bAf, mb1N, mb2N;
    logic        aMb, bMb;  // mail selects, high steers a transfer away from the fifos
    logic [35:0] aDrive, bDrive, aIn, bIn, aOut, bOut, w, w2;
    // expectation notes and bookkeeping
    logic [35:0] expA[$], expB[$];
    logic [35:0] words [0:DEPTH];
    int          err_count, checks_done;

    bdf_core #(.AW(AW)) bdf_core_i (
        .ref_clk(ref_clk), .reset(reset), .portAClock(aClk), .portBClock(bClk),
        .fifo1MasterResetN(rst1N), .fifo2MasterResetN(rst2N), .offsetSelect0(fsel[0]), .offsetSelect1(fsel[1]),
        .timingModeSelect(modeSel), .portASelectN(aSelN), .portADirection(aDir), .portAXferGate(aGate),
        .portAMailSelect(aMb), .portADataIn(aIn), .portADataOut(aOut), .portADataOe(aOe),
        .portASpaceFlag(aSpace), .portADataAvailFlag(aAvail), .almostEmptyPortA(aAe), .almostFullPortA(aAf),
        .portBSelectN(bSelN), .portBDirection(bDir), .portBXferGate(bGate), .portBMailSelect(bMb),
        .portBDataIn(bIn), .portBDataOut(bOut), .portBDataOe(bOe), .portBSpaceFlag(bSpace),
        .portBDataAvailFlag(bAvail), .almostEmptyPortB(bAe), .almostFullPortB(bAf),
        .mail1FullFlagN(mb1N), .mail2FullFlagN(mb2N));
    bdf_port_host #(.READ_DIR(1'b0)) bdf_port_host_a_i (.ref_clk(ref_clk), .portClk(aClk), .selN(aSelN),
        .dir(aDir), .gate(aGate), .drive(aDrive));
    bdf_port_host #(.READ_DIR(1'b1)) bdf_port_host_b_i (.ref_clk(ref_clk), .portClk(bClk), .selN(bSelN),
        .dir(bDir), .gate(bGate), .drive(bDrive));

    // shared data wires: the core wins while it drives, else the host
    assign aIn = aOe ? aOut : aDrive;
    assign bIn = bOe ? bOut : bDrive;

    // 40 MHz system clock
    initial
    begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[ERR] %0t ns: seen %h, expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [35:0] rnd36();
        return {$urandom, 4'($urandom)};
    endfunction

    // port transfers; a read notes its expected word first
    task automatic wrA(input logic [35:0] d);
        bdf_port_host_a_i.cycle(1'b0, 1'b1, 1'b1, d);
    endtask
    task automatic wrB(input logic [35:0] d);
        bdf_port_host_b_i.cycle(1'b0, 1'b0, 1'b1, d);
    endtask
    task automatic rdA(input logic [35:0] e);
        expA.push_back(e);
        bdf_port_host_a_i.cycle(1'b0, 1'b0, 1'b1, 36'h0);
    endtask
    task automatic rdB(input logic [35:0] e);
        expB.push_back(e);
        bdf_port_host_b_i.cycle(1'b0, 1'b1, 1'b1, 36'h0);
    endtask
    // clock both ports with nothing selected
    task automatic idle(input int n);
        repeat (n)
        fork
            bdf_port_host_a_i.cycle(1'b1, 1'b0, 1'b0, 36'h0);
            bdf_port_host_b_i.cycle(1'b1, 1'b0, 1'b0, 36'h0);
        join
    endtask

    // both resets low across five edges of each port clock
    task automatic fifoReset(input logic [1:0] fs, input logic mode);
        @(negedge ref_clk);
        rst1N = 1'b0;
        rst2N = 1'b0;
        fsel = fs;
        // mode level moves only while both fifos are held in reset
        modeSel = mode;
        idle(5);
        check(36'({aSpace, bSpace, aAvail, bAvail, aAe, bAe, aAf, bAf, mb1N, mb2N}), 36'h00f);
        @(negedge ref_clk);
        rst1N = 1'b1;
        rst2N = 1'b1;
        idle(1);
        check(36'(aSpace), 36'h0);
        idle(1);
        check(36'(aSpace), 36'h1);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // result watchers: every read cycle against the oldest note
    always @(bdf_port_host_b_i.done)
        if (bdf_port_host_b_i.wasRead) check(bOut, expB.pop_front());
    always @(bdf_port_host_a_i.done)
        if (bdf_port_host_a_i.wasRead) check(aOut, expA.pop_front());

    // hang guard, far beyond the expected run of about 27 us
    initial
    begin
        #300us;
        err_count++;
        tally_and_finish();
    end

    initial
    begin
        reset = 1'b1;
        rst1N = 1'b1;
        rst2N = 1'b1;
        fsel = 2'h0;
        modeSel = 1'b1;
        aMb = 1'b0;
        bMb = 1'b0;
        err_count = 0;
        checks_done = 0;
        void'($urandom(32'haed2864c));
        repeat (12) @(posedge ref_clk);
        @(negedge ref_clk);
        reset = 1'b0;
        // standard mode, offsets loaded from port a
        fifoReset(2'h0, 1'b1);
        check(36'(bSpace), 36'h0);
        // four offset words in fixed order: y1 random, x1 = 2, y2 = 6, x2 = 1
        wrA(rnd36());
        w = rnd36();
        w[2:0] = 3'h2;
        wrA(w);
        w = rnd36();
        w[2:0] = 3'h6;
        wrA(w);
        w = rnd36();
        w[2:0] = 3'h1;
        wrA(w);
        idle(2);
        check(36'({bSpace, bAvail}), 36'h2);
        $display("test reset_program done");
        // one word, flag rises at the second port b edge, no unrequested load
        words[0] = rnd36();
        wrA(words[0]);
        idle(1);
        check(36'(bAvail), 36'h0);
        idle(1);
        check(36'({bAvail, bAe}), 36'h2);
        check(bOut, 36'h0);
        words[1] = rnd36();
        wrA(words[1]);
        idle(2);
        check(36'(bAe), 36'h0);
        words[2] = rnd36();
        wrA(words[2]);
        idle(2);
        check(36'(bAe), 36'h1);
        for (int i = 0; i < 3; i++) rdB(words[i]);
        rdB(words[2]);
        check(36'(bAvail), 36'h0);
        $display("test standard done");
        // fill fifo1 to refusal, then drain it; almost full is low when full and high when empty for any y1
        for (int i = 0; i <= DEPTH; i++)
        begin
            words[i] = rnd36();
            wrA(words[i]);
            if (i == DEPTH - 1) check(36'({aSpace, aAf}), 36'h0);
        end
        idle(2);
        for (int i = 0; i < DEPTH; i++) rdB(words[i]);
        rdB(words[DEPTH - 1]);
        idle(2);
        check(36'({aSpace, aAf}), 36'h3);
        $display("test full done");
        // mail select high steers a transfer away from both fifos, which stay empty
        aMb = 1'b1;
        bMb = 1'b1;
        wrA(rnd36());
        wrB(rnd36());
        idle(2);
        check(36'({bAvail, aAvail}), 36'h0);
        aMb = 1'b0;
        bMb = 1'b0;
        $display("test mail_select done");
        // port b into fifo2, read back on port a; x2 = 1 and y2 = 6 set the almost levels
        for (int i = 0; i < 3; i++)
        begin
            words[i] = rnd36();
            wrB(words[i]);
        end
        idle(2);
        check(36'({aAvail, aAe, bAf}), 36'h6);
        for (int i = 0; i < 3; i++) rdA(words[i]);
        idle(2);
        check(36'({aAvail, aAe, bAf}), 36'h1);
        $display("test b_to_a done");
        // every select and direction level on both ports
        for (int k = 0; k < 4; k++)
        begin
            bdf_port_host_a_i.pins(k[1], k[0]);
            bdf_port_host_b_i.pins(k[1], k[0]);
            repeat (8) @(negedge ref_clk);
            check(36'({aOe, bOe}), 36'({!k[1] && !k[0], !k[1] && k[0]}));
        end
        $display("test enables done");
        // fall-through with preset offsets: port b needs no offset load
        fifoReset(2'h1, 1'b0);
        check(36'(bSpace), 36'h1);
        w = rnd36();
        wrA(w);
        idle(2);
        check(36'(bAvail), 36'h0);
        idle(1);
        check(36'(bAvail), 36'h1);
        check(bOut, w);
        w2 = rnd36();
        wrA(w2);
        idle(3);
        check(bOut, w);
        rdB(w2);
        rdB(w2);
        rdB(w2);
        check(36'(bAvail), 36'h0);
        $display("test fall_through done");
        tally_and_finish();
    end
endmodule
